// >>> src/seeacc_engine.sv
`timescale 1ns/1ps
`include "seeacc_regs.svh"

// Behaviour
// R01 - Lowest control bit picks direction: 0 write, 1 read.
// R02 - Upper five control bits select one of 32 rows.
// R03 - Control byte copies addressed row into 16-bit staging buffer.
// R04 - Mode bits set write byte order; data bytes overwrite staging in order.
// R05 - Master writes with START, control byte, one or two bytes, STOP.
// R06 - STOP after a write data byte starts erase then write-back of row.
// R07 - Erase-write cycle keeps the device busy about ten milliseconds.
// R08 - While programming, inputs ignored and no control byte acknowledged.
// R09 - Master polls with START plus control byte until acknowledged.
// R10 - Read control byte: acknowledge, load row, send mode-selected byte first.
// R11 - After both bytes read, step row and reload staging buffer.
// R12 - Read mode 01 low first incrementing, 10 high first decrementing.
// R13 - Row address wraps at either end during sequential reads.
// R14 - Master acknowledges to continue, ends read with no-acknowledge then STOP.
// R15 - Two dedicated control bytes fill the whole memory with zeros or ones.
// R16 - Data changes only while clock low; changes while high are START/STOP.
// R17 - Missing master acknowledge stops transmission and returns to receive.
// R18 - Between STOP and START the data line is released to the pull-up.
// R19 - Sample incoming bits on rising clock; change outgoing bits while low.
// R20 - Acknowledge accepted control and write bytes by pulling data low.
module seeacc_engine #(
  parameter int PROG_CYCLES = `SEEACC_PROG_CYCLES
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  output logic BUSY
);
  seeacc_pkg::seeacc_state_type state_q;
  seeacc_pkg::seeacc_fill_type fill_q;
  logic [15:0] mem [0:31];
  logic scl_s1_q, scl_s2_q, scl_s3_q, scl_f_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q, sda_f_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [4:0] row_q;
  logic [1:0] mode_q;
  logic rd_q;
  logic [15:0] stage_q;
  logic byte_n_q;
  logic [1:0] wr_cnt_q;
  logic wr_idx_q;
  logic mack_q;
  logic prog_pend_q;
  logic busy_q;
  logic [19:0] busy_cnt_q;
  logic sda_oe_n_q;
  logic sda_o_q;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    pick_byte = hi ? w[15:8] : w[7:0];
  endfunction

  // Filtered line levels: a change counts once the second and third stages agree
  wire scl_f_d = (scl_s2_q == scl_s3_q) ? scl_s3_q : scl_f_q;
  wire sda_f_d = (sda_s2_q == sda_s3_q) ? sda_s3_q : sda_f_q;
  wire scl_rise = scl_f_d & ~scl_f_q;
  wire scl_fall = ~scl_f_d & scl_f_q;
  wire scl_high = scl_f_d & scl_f_q;
  wire start_cond = scl_high & sda_f_q & ~sda_f_d; // R16
  wire stop_cond = scl_high & ~sda_f_q & sda_f_d; // R16
  wire byte_done = (cnt_q == `SEEACC_BITS_PER_BYTE);

  // Control byte decoding
  wire [4:0] ctrl_row = shift_q[7:`SEEACC_CTRL_ROW_LSB]; // R02
  wire [1:0] ctrl_mode = shift_q[`SEEACC_CTRL_MODE_LSB +: 2];
  wire ctrl_rd = shift_q[`SEEACC_CTRL_DIR_BIT]; // R01
  wire ctrl_special = (shift_q[2:0] == `SEEACC_SPECIAL_LOW) &&
    (shift_q[7:6] == `SEEACC_SPECIAL_HIGH);
  wire ctrl_reserved = (shift_q[2:0] == `SEEACC_RESERVED_LOW);
  wire ctrl_fill0 = (shift_q == `SEEACC_CMD_FILL_ZERO); // R15
  wire ctrl_fill1 = (shift_q == `SEEACC_CMD_FILL_ONE); // R15
  wire ctrl_ok = ~(ctrl_special | ctrl_reserved);

  // Read sequencing
  wire [4:0] row_next = mode_q[1] ? row_q - 5'h01 : row_q + 5'h01; // R12 R13
  wire rd_hi = mode_q[1] ^ byte_n_q; // R12
  wire [7:0] rd_byte = pick_byte(stage_q, rd_hi);

  // Write data path into the two-entry buffer
  wire wr_take = (state_q == seeacc_pkg::ST_WDATA) & scl_fall & byte_done &
    (wr_cnt_q != 2'h2) & fifo_in_ready;
  wire drain_ready = ~busy_q;
  wire drain = fifo_out_valid & drain_ready;
  wire wr_hi = mode_q[1] ^ wr_idx_q; // R04
  wire prog_done = busy_q && (busy_cnt_q == 20'(PROG_CYCLES - 1));
  wire stop_prog = ~rd_q & ((wr_cnt_q != 2'h0) | (fill_q != seeacc_pkg::FILL_NONE)) &
    ((state_q == seeacc_pkg::ST_WDATA) | (state_q == seeacc_pkg::ST_WACK));

  seeacc_buf2 #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_wbuf (
    .clk(MCLK),
    .rst(RST),
    .in_valid(wr_take),
    .in_ready(fifo_in_ready),
    .in_data(shift_q),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      scl_f_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      sda_f_q <= 1'b1;
    end
    else
    begin
      scl_s1_q <= SCL;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      scl_f_q <= scl_f_d;
      sda_s1_q <= SDA_I;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      sda_f_q <= sda_f_d;
    end
  end

  // Nonvolatile array: written only at the end of a programming cycle
  always_ff @(posedge MCLK)
  begin
    if (prog_done)
    begin
      for (int i = 0; i < 32; i++)
      begin
        if (fill_q == seeacc_pkg::FILL_ZERO)
          mem[i] <= 16'h0000; // R15
        else if (fill_q == seeacc_pkg::FILL_ONE)
          mem[i] <= 16'hFFFF; // R15
        else if (5'(i) == row_q)
          mem[i] <= stage_q; // R06
      end
    end
  end

  // Programming timer
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      busy_q <= 1'b0;
      busy_cnt_q <= 20'h00000;
      prog_pend_q <= 1'b0;
    end
    else
    begin
      if (stop_cond && stop_prog)
        prog_pend_q <= 1'b1; // R06
      else if (prog_pend_q && !fifo_out_valid)
        prog_pend_q <= 1'b0;
      if (prog_pend_q && !fifo_out_valid)
      begin
        busy_q <= 1'b1;
        busy_cnt_q <= 20'h00000;
      end
      else if (prog_done)
        busy_q <= 1'b0; // R07
      else if (busy_q)
        busy_cnt_q <= busy_cnt_q + 20'h00001; // R07
    end
  end

  // Serial protocol engine
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= seeacc_pkg::ST_IDLE;
      fill_q <= seeacc_pkg::FILL_NONE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      row_q <= 5'h00;
      mode_q <= 2'h0;
      rd_q <= 1'b0;
      stage_q <= 16'h0000;
      byte_n_q <= 1'b0;
      wr_cnt_q <= 2'h0;
      wr_idx_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      sda_o_q <= 1'b0;
    end
    else
    begin
      sda_o_q <= 1'b0;
      if (drain)
      begin
        if (wr_hi)
          stage_q[15:8] <= fifo_out_data; // R04
        else
          stage_q[7:0] <= fifo_out_data; // R04
        wr_idx_q <= ~wr_idx_q;
      end
      if (stop_cond)
      begin
        state_q <= seeacc_pkg::ST_IDLE;
        sda_oe_n_q <= 1'b1; // R18
      end
      else if (start_cond)
      begin
        cnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
        // A start during programming is not acknowledged and keeps the pending command
        if (busy_q || prog_pend_q)
          state_q <= seeacc_pkg::ST_IGNORE; // R08
        else
        begin
          state_q <= seeacc_pkg::ST_CTRL;
          wr_cnt_q <= 2'h0;
          wr_idx_q <= 1'b0;
          byte_n_q <= 1'b0;
          fill_q <= seeacc_pkg::FILL_NONE;
        end
      end
      else
      begin
        case (state_q)
          seeacc_pkg::ST_CTRL, seeacc_pkg::ST_WDATA:
          begin
            if (scl_rise && !byte_done)
            begin
              shift_q <= {shift_q[6:0], sda_f_q}; // R19
              cnt_q <= cnt_q + 4'h1;
            end
            else if (scl_fall && byte_done && state_q == seeacc_pkg::ST_CTRL)
            begin
              if (ctrl_ok)
              begin
                sda_oe_n_q <= 1'b0; // R20
                row_q <= ctrl_row;
                mode_q <= ctrl_mode;
                rd_q <= ctrl_rd;
                stage_q <= mem[ctrl_row]; // R03 R10
                if (ctrl_fill0 && !ctrl_rd)
                  fill_q <= seeacc_pkg::FILL_ZERO;
                else if (ctrl_fill1 && !ctrl_rd)
                  fill_q <= seeacc_pkg::FILL_ONE;
                state_q <= seeacc_pkg::ST_CACK;
              end
              else
                state_q <= seeacc_pkg::ST_IGNORE;
            end
            else if (scl_fall && byte_done)
            begin
              if (wr_take)
              begin
                sda_oe_n_q <= 1'b0; // R20
                wr_cnt_q <= wr_cnt_q + 2'h1;
                state_q <= seeacc_pkg::ST_WACK;
              end
              // A third byte goes unacknowledged; STOP still programs the bytes taken
              else if (wr_cnt_q != 2'h2)
                state_q <= seeacc_pkg::ST_IGNORE;
            end
          end
          seeacc_pkg::ST_CACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (rd_q)
              begin
                sda_oe_n_q <= rd_byte[7]; // R10 R19
                tx_q <= {rd_byte[6:0], 1'b0};
                state_q <= seeacc_pkg::ST_RDATA;
              end
              else
              begin
                sda_oe_n_q <= 1'b1;
                state_q <= seeacc_pkg::ST_WDATA;
              end
            end
          end
          seeacc_pkg::ST_WACK:
          begin
            if (scl_fall)
            begin
              sda_oe_n_q <= 1'b1;
              cnt_q <= 4'h0;
              state_q <= seeacc_pkg::ST_WDATA;
            end
          end
          seeacc_pkg::ST_RDATA:
          begin
            if (scl_rise)
              cnt_q <= cnt_q + 4'h1;
            else if (scl_fall && byte_done)
            begin
              sda_oe_n_q <= 1'b1;
              state_q <= seeacc_pkg::ST_RACK;
            end
            else if (scl_fall)
            begin
              sda_oe_n_q <= tx_q[7]; // R19
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          seeacc_pkg::ST_RACK:
          begin
            if (scl_rise)
            begin
              mack_q <= ~sda_f_q;
              if (!sda_f_q)
              begin
                byte_n_q <= ~byte_n_q;
                if (byte_n_q)
                begin
                  row_q <= row_next; // R11 R13
                  stage_q <= mem[row_next]; // R11
                end
              end
            end
            else if (scl_fall)
            begin
              cnt_q <= 4'h0;
              if (mack_q)
              begin
                sda_oe_n_q <= rd_byte[7];
                tx_q <= {rd_byte[6:0], 1'b0};
                state_q <= seeacc_pkg::ST_RDATA;
              end
              else
                state_q <= seeacc_pkg::ST_IGNORE; // R17
            end
          end
          default:
          begin
            sda_oe_n_q <= 1'b1; // R18
          end
        endcase
      end
    end
  end

  assign SDA_O = sda_o_q;
  assign SDA_OE_N = sda_oe_n_q;
  assign BUSY = busy_q;
endmodule

// >>> src/seeacc_regs.svh
`ifndef SEEACC_REGS_SVH
`define SEEACC_REGS_SVH

// Clock rate and erase-write time
`define SEEACC_MCLK_HZ 40000000
`define SEEACC_PROG_TIME_MS 10
`define SEEACC_PROG_CYCLES ((`SEEACC_PROG_TIME_MS * `SEEACC_MCLK_HZ) / 1000)

// Control byte fields
`define SEEACC_CTRL_DIR_BIT 0
`define SEEACC_CTRL_MODE_LSB 1
`define SEEACC_CTRL_ROW_LSB 3
`define SEEACC_BITS_PER_BYTE 4'h8

// Memory initialisation commands
`define SEEACC_CMD_FILL_ZERO 8'h00
`define SEEACC_CMD_FILL_ONE 8'hF8

// Control bytes for modes outside this block
`define SEEACC_SPECIAL_LOW 3'h7
`define SEEACC_SPECIAL_HIGH 2'h3
`define SEEACC_RESERVED_LOW 3'h6

`endif

// >>> src/seeacc_pkg.sv
package seeacc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_CACK = 3'b010,
    ST_WDATA = 3'b011,
    ST_WACK = 3'b100,
    ST_RDATA = 3'b101,
    ST_RACK = 3'b110,
    ST_IGNORE = 3'b111
  } seeacc_state_type;

  typedef enum logic [1:0] {
    FILL_NONE = 2'b00,
    FILL_ZERO = 2'b01,
    FILL_ONE = 2'b10
  } seeacc_fill_type;

endpackage

// >>> src/seeacc_buf2.sv
`timescale 1ns/1ps
module seeacc_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW-1:0] wptr_q;
  logic [PW-1:0] rptr_q;
  logic [PW:0] count_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (count_q != (PW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = store[rptr_q];

  function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
    ptr_next = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      store[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wptr_q <= ptr_next(wptr_q);
      if (pop)
        rptr_q <= ptr_next(rptr_q);
      if (push && !pop)
        count_q <= count_q + 1'b1;
      else if (pop && !push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule

// >>> testbench/seeacc_monitor.sv
`timescale 1ns/1ps
module seeacc_monitor #(
  parameter int PROG_CYCLES = 200
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_N,
  input wire logic BUSY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);
  logic sda_q;
  logic stop_d;
  logic len_ok;
  logic [31:0] len_q;
  logic [7:0] gap_q;
  assign stop_d = SCL && SDA_I && !sda_q;
  assign len_ok = len_q + 32'h1 >= PROG_CYCLES && len_q <= PROG_CYCLES + 1;
  // Busy length and cycles since the last stop
  always_ff @(posedge MCLK)
  begin
    sda_q <= SDA_I;
    len_q <= BUSY ? len_q + 32'h1 : 32'h0;
    gap_q <= stop_d ? 8'h0 : gap_q + {7'h0, gap_q != 8'hFF};
  end
  a_open_drain: assert property (!SDA_OE_N |-> !SDA_O)
    else $error("data line driven high");
  a_ack_stands: assert property ($fell(SDA_OE_N) |-> !SDA_OE_N [*8])
    else $error("drive shorter than a clock phase");
  a_moves_low: assert property ($changed(SDA_OE_N) |-> !SCL)
    else $error("data changed while clock high");
  a_stop_idle: assert property (stop_d |-> SDA_OE_N [*8])
    else $error("line not released after stop");
  a_busy_quiet: assert property (BUSY |-> SDA_OE_N)
    else $error("drive while programming");
  a_prog_after_stop: assert property ($rose(BUSY) |-> gap_q < 8'h10)
    else $error("programming began without stop");
  a_prog_length: assert property ($fell(BUSY) |-> len_ok)
    else $error("programming length wrong");
  a_reset_idle: assert property ($fell(RST) |-> SDA_OE_N && !BUSY)
    else $error("not idle after reset");
  c_prog: cover property ($rose(BUSY));
  c_drive: cover property ($fell(SDA_OE_N));
  c_stop: cover property (stop_d);
endmodule

// >>> testbench/seeacc_master.sv
`timescale 1ns/1ps
module seeacc_master (
  input wire logic mclk,
  input wire logic sda_in,
  output logic scl,
  output logic sda
);
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Phases of 8 cycles leave room for the engine's input filter
  task automatic bitx(input logic b, output logic r);
    q(4);
    sda = b;
    q(4);
    scl = 1'b1;
    q(8);
    r = sda_in;
    scl = 1'b0;
  endtask
  task automatic start();
    q(4);
    sda = 1'b1;
    q(4);
    scl = 1'b1;
    q(8);
    sda = 1'b0;
    q(8);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(4);
    sda = 1'b0;
    q(4);
    scl = 1'b1;
    q(8);
    sda = 1'b1;
    q(8);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // Last byte gets no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule

// >>> testbench/serial_eeprom_access_engine_tb.sv
`timescale 1ns/1ps
module serial_eeprom_access_engine_tb;
  localparam int PROG = 200;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic scl;
  logic sda_m;
  logic SDA_O;
  logic SDA_OE_N;
  logic BUSY;
  wire sda_w = sda_m & (SDA_OE_N | SDA_O);
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 MCLK = ~MCLK;
  seeacc_engine #(.PROG_CYCLES(PROG)) i_seeacc_engine (.MCLK(MCLK), .RST(RST),
    .SCL(scl), .SDA_I(sda_w), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY));
  seeacc_master i_seeacc_master (.mclk(MCLK), .sda_in(sda_w), .scl(scl), .sda(sda_m));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Control byte, then n data bytes from the top of w; a third byte is refused
  task automatic wr(input logic [7:0] c, input logic ca, input int n, input logic [23:0] w);
    logic a;
    i_seeacc_master.start();
    i_seeacc_master.wbyte(c, a);
    chk(a, ca);
    for (int i = 0; i < n; i++)
    begin
      i_seeacc_master.wbyte(w[23-8*i -: 8], a);
      chk(a, i < 2);
    end
    i_seeacc_master.stop();
  endtask
  task automatic rd(input logic [7:0] c, input int n, input logic [63:0] e);
    logic a;
    logic [7:0] d;
    i_seeacc_master.start();
    i_seeacc_master.wbyte(c, a);
    chk(a, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_seeacc_master.rbyte(i == n - 1, d);
      chk(d, e[63-8*i -: 8]);
    end
    i_seeacc_master.rbyte(1'b1, d);
    chk(d, 8'hFF);
    i_seeacc_master.stop();
  endtask
  // Retry until programming ends, then read the low byte of row 0
  task automatic poll(input logic [7:0] e);
    logic a;
    logic [7:0] d;
    int n;
    n = 0;
    a = 1'b0;
    while (!a && n < 20)
    begin
      i_seeacc_master.start();
      i_seeacc_master.wbyte(8'h03, a);
      if (a)
        i_seeacc_master.rbyte(1'b1, d);
      i_seeacc_master.stop();
      n++;
    end
    chk(n > 1, 1'b1);
    chk(d, e);
  endtask
  task automatic t_fill();
    wr(8'h06, 1'b0, 0, 24'h0);
    chk(BUSY, 1'b0);
    wr(8'h00, 1'b1, 0, 24'h0);
    poll(8'h00);
    rd(8'h8B, 2, 64'h0);
    wr(8'hF8, 1'b1, 0, 24'h0);
    poll(8'hFF);
  endtask
  task automatic t_write();
    wr(8'h02, 1'b1, 3, 24'h341277);
    poll(8'h34);
    wr(8'h0C, 1'b1, 2, 24'hABCD00);
    poll(8'h34);
    wr(8'h14, 1'b1, 1, 24'h5A0000);
    poll(8'h34);
  endtask
  task automatic t_read();
    rd(8'h03, 6, 64'h3412CDABFF5A0000);
    rd(8'h15, 8, 64'h5AFFABCD1234FFFF);
    rd(8'hFB, 4, 64'hFFFF341200000000);
  endtask
  initial
  begin
    repeat (20) @(negedge MCLK);
    RST = 1'b0;
    repeat (4) @(negedge MCLK);
    t_fill();
    t_write();
    t_read();
    end_sim();
  end
  always @(posedge MCLK)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      end_sim();
    end
  end
endmodule
bind seeacc_engine seeacc_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_seeacc_monitor (.MCLK(MCLK),
  .RST(RST), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N), .BUSY(BUSY));
